/* File: iam_pkg.sv */
// ==========================================================
// Behaviour
// - general call answered only when enabled
// - width select: 0 seven-bit, 1 ten-bit
// - reserved control bit reads zero, ignores writes
// - independent rate bit decouples slave from master
// - independent rate stretches clock for slow capture
// - range match: above primary, up to upper
// - range disabled means no span matching
// - low three bits: ten-bit address high bits
// - holdoff enabled delays stop during transfer
// - byte in flight finishes before stop proceeds
// - acknowledge stop request after byte completes
// - idle or disabled acknowledges stop at once
// - holdoff disabled never delays stop entry
package iam_pkg;

   // ==========================================================
   // register map (byte offsets on the plain port)
   localparam logic [3:0] PRIMARY_ADDR_OFS = 4'h0; // primary slave address
   localparam logic [3:0] ADDR_MODE_OFS = 4'h5; // address_mode_control
   localparam logic [3:0] FILTER_STOP_OFS = 4'h6; // filter_and_stop_control
   localparam logic [3:0] RANGE_UPPER_OFS = 4'h7; // range_upper_address
   localparam logic [3:0] SLAVE_CTRL_OFS = 4'h8; // module enable
   localparam logic [3:0] SLAVE_STAT_OFS = 4'h9; // live status, read only

   // ==========================================================
   // field positions
   localparam int GEN_CALL_EN_BIT = 7; // general_call_enable
   localparam int ADDR_WIDTH_BIT = 6; // address_width_select
   localparam int INDEP_RATE_BIT = 4; // independent_slave_rate
   localparam int RANGE_EN_BIT = 3; // range_match_enable
   localparam int HOLDOFF_EN_BIT = 7; // stop_holdoff_enable
   localparam logic [7:0] ADDR_MODE_WMASK = 8'hdf; // bit 5 reserved
   localparam logic [7:0] FILTER_WMASK = 8'h80; // only holdoff kept here
   localparam logic [7:0] ADDR7_WMASK = 8'hfe; // bit 0 reserved
   localparam logic [7:0] REG_RESET = 8'h00; // every register resets clear

   // ==========================================================
   // bus constants
   localparam logic [4:0] TEN_BIT_HDR = 5'h1e; // 11110 prefix
   localparam logic [6:0] GEN_CALL_ADDR = 7'h00; // general call
   localparam logic [3:0] BIT_LAST = 4'h7; // eighth bit index
   localparam logic [3:0] BIT_ACK = 4'h8; // acknowledge slot

   // ==========================================================
   // timing
   localparam int CLK_NS = 10; // 100 MHz reference clock
   localparam int SLAVE_BIT_NS = 1000; // least slave capture time per bit
   localparam int SLAVE_BIT_CYC = (SLAVE_BIT_NS + CLK_NS - 1) / CLK_NS; // rounded up

   // ==========================================================
   // types
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0, // no transfer seen
      ST_FIRST = 3'h1, // first address byte
      ST_SECOND = 3'h3, // ten-bit second byte
      ST_DATA = 3'h2, // addressed, moving data
      ST_SKIP = 3'h6 // not addressed, watching only
   } iam_state_type;

   typedef struct packed {
      logic scl; // clock line level
      logic sda; // data line level
   } iam_pins_type;

   typedef struct packed {
      logic [3:0] addr; // register offset
      logic [7:0] wdata; // write data
      logic wr; // write strobe
      logic rd; // read strobe
   } iam_bus_type;

endpackage

/* File: iam_pin_sync.sv */
`timescale 1ns/100ps
// two-flop synchroniser plus a history flop for edge detection
module iam_pin_sync (
   input wire logic i_ref_clk, // reference clock
   input wire logic i_nrst, // async reset, active low
   input wire iam_pkg::iam_pins_type i_pins, // raw bus lines
   output iam_pkg::iam_pins_type o_level, // synchronised level
   output iam_pkg::iam_pins_type o_prev // level one cycle earlier
);

   // ==========================================================
   // state
   typedef struct packed {
      iam_pkg::iam_pins_type meta; // first stage, read by second only
      iam_pkg::iam_pins_type level; // second stage
      iam_pkg::iam_pins_type prev; // history for edges
   } iam_sync_type;

   iam_sync_type st;
   iam_sync_type next_st;

   // idle lines are high, so reset to high avoids false edges
   always_comb begin
      next_st = st;
      next_st.meta = i_pins;
      next_st.level = st.meta;
      next_st.prev = st.level;
   end

   // register the copy
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st <= '1;
      end else begin
         st <= next_st;
      end
   end

   assign o_level = st.level;
   assign o_prev = st.prev;

endmodule

/* File: iam_addr_match.sv */
`timescale 1ns/100ps
// slave address matcher with stop-mode holdoff
module iam_addr_match #(
   parameter int SLAVE_BIT_CYC = iam_pkg::SLAVE_BIT_CYC // slave capture cycles per bit
) (
   input wire logic i_ref_clk, // reference clock
   input wire logic i_nrst, // async reset, active low
   input wire iam_pkg::iam_bus_type i_bus, // register port request
   output logic [7:0] o_rd_data, // read data, cycle after strobe
   input wire logic i_scl, // clock line level
   input wire logic i_sda, // data line level
   output logic o_scl_out, // clock line drive value
   output logic o_scl_oe_n, // low while stretching clock
   output logic o_sda_out, // data line drive value
   output logic o_sda_oe_n, // low while acknowledging
   input wire logic i_stop_req, // stop-mode request, same clock
   output logic o_stop_ack, // stop-mode acknowledge
   output logic o_addressed // slave currently addressed
);

   localparam int TW = $clog2(SLAVE_BIT_CYC + 1); // timer width
   // start leaves the counter one below zero: the start's own clock fall
   // wraps it to 0, so it is not mistaken for the end of a data bit
   localparam logic [3:0] BIT_WAIT_FIRST = 4'hf; // before first data bit

   // ==========================================================
   // state
   typedef struct packed {
      logic [7:0] primary; // primary_slave_address
      logic [7:0] mode; // address_mode_control
      logic [7:0] filt; // filter_and_stop_control
      logic [7:0] upper; // range_upper_address
      logic enable; // module enable
      iam_pkg::iam_state_type fsm; // byte level state
      logic [3:0] bit_cnt; // bit within byte, 8 is ack slot
      logic [7:0] shift; // received bits
      logic rw; // read/write bit of address
      logic addressed; // matched since last stop
      logic gen_call; // match was general call
      logic ack_drv; // pulling data low
      logic stretch; // pulling clock low
      logic [TW-1:0] cap_tmr; // cycles since last capture
      logic stop_ack; // acknowledge to power controller
      logic [7:0] rd_data; // read data output
   } iam_top_type;

   iam_top_type st;
   iam_top_type next_st;

   iam_pkg::iam_pins_type pins_lvl; // synchronised lines
   iam_pkg::iam_pins_type pins_prev; // previous sample
   iam_pkg::iam_pins_type pins_raw; // pin bundle

   assign pins_raw = '{scl: i_scl, sda: i_sda};

   // ==========================================================
   // pin synchroniser
   iam_pin_sync u_sync (
      .i_ref_clk(i_ref_clk),
      .i_nrst(i_nrst),
      .i_pins(pins_raw),
      .o_level(pins_lvl),
      .o_prev(pins_prev)
   );

   // ==========================================================
   // line events
   logic scl_rise; // clock rising, data captured
   logic scl_fall; // clock falling, bit ends
   logic start_det; // data falls with clock high
   logic stop_det; // data rises with clock high
   assign scl_rise = pins_lvl.scl & ~pins_prev.scl;
   assign scl_fall = ~pins_lvl.scl & pins_prev.scl;
   assign start_det = pins_lvl.scl & pins_prev.scl & pins_prev.sda & ~pins_lvl.sda;
   assign stop_det = pins_lvl.scl & pins_prev.scl & ~pins_prev.sda & pins_lvl.sda;

   // ==========================================================
   // address compare, valid once eight bits are in
   logic [6:0] addr7; // seven-bit address field
   logic ten_bit; // address_width_select
   logic gc_hit; // general call seen and enabled
   logic prim_hit; // primary seven-bit match
   logic range_hit; // range match
   logic hdr_hit; // ten-bit header matches upper bits
   logic low_hit; // ten-bit second byte matches
   logic byte_busy; // a byte is on the wire

   always_comb begin
      addr7 = st.shift[7:1];
      ten_bit = st.mode[iam_pkg::ADDR_WIDTH_BIT];
      // general call only while its enable is set
      gc_hit = st.mode[iam_pkg::GEN_CALL_EN_BIT] && (addr7 == iam_pkg::GEN_CALL_ADDR)
         && !st.shift[0];
      prim_hit = (addr7 == st.primary[7:1]);
      // strictly above primary and up to the upper bound, only when enabled
      range_hit = st.mode[iam_pkg::RANGE_EN_BIT] && (addr7 > st.primary[7:1])
         && (addr7 <= st.upper[7:1]);
      // upper address bits come from the low control bits in ten-bit mode
      hdr_hit = (st.shift[7:3] == iam_pkg::TEN_BIT_HDR)
         && (st.shift[2:1] == st.mode[2:1]);
      low_hit = (st.shift == {st.mode[0], st.primary[7:1]});
      byte_busy = (st.fsm != iam_pkg::ST_IDLE) && (st.bit_cnt != 4'h0);
   end

   // ==========================================================
   // next state
   always_comb begin
      next_st = st;
      next_st.rd_data = 8'h00;

      // ---------- register writes
      if (i_bus.wr) begin
         case (i_bus.addr)
            iam_pkg::PRIMARY_ADDR_OFS: begin
               next_st.primary = i_bus.wdata & iam_pkg::ADDR7_WMASK;
            end
            iam_pkg::ADDR_MODE_OFS: begin
               // reserved bit never stored
               next_st.mode = i_bus.wdata & iam_pkg::ADDR_MODE_WMASK;
            end
            iam_pkg::FILTER_STOP_OFS: begin
               next_st.filt = i_bus.wdata & iam_pkg::FILTER_WMASK;
            end
            iam_pkg::RANGE_UPPER_OFS: begin
               next_st.upper = i_bus.wdata & iam_pkg::ADDR7_WMASK;
            end
            iam_pkg::SLAVE_CTRL_OFS: begin
               next_st.enable = i_bus.wdata[0];
            end
            default: begin
               // unmapped writes are dropped
            end
         endcase
      end

      // ---------- register reads, data in the following cycle
      if (i_bus.rd) begin
         case (i_bus.addr)
            iam_pkg::PRIMARY_ADDR_OFS: next_st.rd_data = st.primary;
            iam_pkg::ADDR_MODE_OFS: next_st.rd_data = st.mode;
            iam_pkg::FILTER_STOP_OFS: next_st.rd_data = st.filt;
            iam_pkg::RANGE_UPPER_OFS: next_st.rd_data = st.upper;
            iam_pkg::SLAVE_CTRL_OFS: next_st.rd_data = {7'h00, st.enable};
            iam_pkg::SLAVE_STAT_OFS: begin
               next_st.rd_data = {3'h0, st.stretch, st.gen_call, st.stop_ack,
                  byte_busy, st.addressed};
            end
            default: next_st.rd_data = 8'h00; // unmapped reads as zero
         endcase
      end

      // ---------- capture timer, measures the slave's own bit time
      if (scl_rise) begin
         next_st.cap_tmr = '0;
      end else if (st.cap_tmr != TW'(SLAVE_BIT_CYC)) begin
         next_st.cap_tmr = st.cap_tmr + TW'(1);
      end

      // ---------- clock stretching
      // with the independent rate the slave holds the clock low until its
      // own capture time has run; otherwise it follows the master freely
      if (st.stretch) begin
         if (st.cap_tmr == TW'(SLAVE_BIT_CYC)) begin
            next_st.stretch = 1'b0;
         end
      end else if (scl_fall && st.enable && st.mode[iam_pkg::INDEP_RATE_BIT]
            && (st.fsm != iam_pkg::ST_IDLE) && (st.cap_tmr != TW'(SLAVE_BIT_CYC))) begin
         next_st.stretch = 1'b1;
      end
      if (!st.mode[iam_pkg::INDEP_RATE_BIT] || !st.enable) begin
         next_st.stretch = 1'b0;
      end

      // ---------- bit and byte sequencing
      if (!st.enable) begin
         next_st.fsm = iam_pkg::ST_IDLE;
         next_st.bit_cnt = 4'h0;
         next_st.ack_drv = 1'b0;
         next_st.addressed = 1'b0;
         next_st.gen_call = 1'b0;
      end else if (stop_det) begin
         next_st.fsm = iam_pkg::ST_IDLE;
         next_st.bit_cnt = 4'h0;
         next_st.ack_drv = 1'b0;
         next_st.addressed = 1'b0;
         next_st.gen_call = 1'b0;
      end else if (start_det) begin
         // repeated start keeps the addressed flag for ten-bit reads
         next_st.fsm = iam_pkg::ST_FIRST;
         next_st.bit_cnt = BIT_WAIT_FIRST; // start's clock fall wraps to 0
         next_st.ack_drv = 1'b0;
      end else if (st.fsm != iam_pkg::ST_IDLE) begin
         if (scl_rise && (st.bit_cnt <= iam_pkg::BIT_LAST)) begin
            next_st.shift = {st.shift[6:0], pins_lvl.sda};
         end
         if (scl_fall) begin
            if (st.bit_cnt == iam_pkg::BIT_LAST) begin
               // eighth bit done: decide on acknowledge for the ninth
               next_st.bit_cnt = iam_pkg::BIT_ACK;
               case (st.fsm)
                  iam_pkg::ST_FIRST: begin
                     next_st.rw = st.shift[0];
                     if (ten_bit) begin
                        next_st.ack_drv = hdr_hit && (!st.shift[0] || st.addressed);
                     end else begin
                        next_st.ack_drv = gc_hit || prim_hit || range_hit;
                        next_st.addressed = gc_hit || prim_hit || range_hit;
                        next_st.gen_call = gc_hit && !prim_hit;
                     end
                  end
                  iam_pkg::ST_SECOND: begin
                     next_st.ack_drv = low_hit;
                     next_st.addressed = low_hit;
                  end
                  iam_pkg::ST_DATA: next_st.ack_drv = !st.rw;
                  default: next_st.ack_drv = 1'b0;
               endcase
            end else if (st.bit_cnt == iam_pkg::BIT_ACK) begin
               // acknowledge slot done, byte is complete
               next_st.bit_cnt = 4'h0;
               next_st.ack_drv = 1'b0;
               case (st.fsm)
                  iam_pkg::ST_FIRST: begin
                     if (!st.ack_drv) begin
                        next_st.fsm = iam_pkg::ST_SKIP;
                     end else if (ten_bit && !st.rw) begin
                        next_st.fsm = iam_pkg::ST_SECOND;
                     end else begin
                        next_st.fsm = iam_pkg::ST_DATA;
                     end
                  end
                  iam_pkg::ST_SECOND: begin
                     next_st.fsm = st.ack_drv ? iam_pkg::ST_DATA : iam_pkg::ST_SKIP;
                  end
                  default: next_st.fsm = st.fsm;
               endcase
            end else begin
               next_st.bit_cnt = st.bit_cnt + 4'h1;
            end
         end
      end

      // ---------- stop-mode handshake
      // the power controller waits for this acknowledge before gating
      // our clock, so holding it back keeps the byte alive
      if (!i_stop_req) begin
         next_st.stop_ack = 1'b0;
      end else if (!st.filt[iam_pkg::HOLDOFF_EN_BIT]) begin
         next_st.stop_ack = 1'b1;
      end else if (!st.enable || (st.fsm == iam_pkg::ST_IDLE)) begin
         next_st.stop_ack = 1'b1;
      end else if (!byte_busy) begin
         // between bytes, or the in-flight byte just closed its ack slot
         next_st.stop_ack = 1'b1;
      end
   end

   // ==========================================================
   // register the copy
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st <= '{primary: iam_pkg::REG_RESET, mode: iam_pkg::REG_RESET,
            filt: iam_pkg::REG_RESET, upper: iam_pkg::REG_RESET,
            fsm: iam_pkg::ST_IDLE, default: '0};
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // outputs straight from flops, drive values tied low; pins only ever pull low
   assign o_rd_data = st.rd_data;
   assign o_scl_out = 1'b0;
   assign o_scl_oe_n = ~st.stretch;
   assign o_sda_out = 1'b0;
   assign o_sda_oe_n = ~st.ack_drv;
   assign o_stop_ack = st.stop_ack;
   assign o_addressed = st.addressed;

endmodule

/* File: iam_addr_match_monitor.sv */
`timescale 1ns/100ps
// ==========================================================
// checker for the address matcher, top ports only
module iam_addr_match_monitor #(
   parameter int SLAVE_BIT_CYC = iam_pkg::SLAVE_BIT_CYC // capture cycles per bit
) (
   input wire logic i_ref_clk, // reference clock
   input wire logic i_nrst, // async reset, active low
   input wire iam_pkg::iam_bus_type i_bus, // register port
   input wire logic [7:0] o_rd_data, // read data
   input wire logic i_scl, // clock line
   input wire logic i_sda, // data line
   input wire logic o_scl_out, // clock drive value
   input wire logic o_scl_oe_n, // low while stretching
   input wire logic o_sda_out, // data drive value
   input wire logic o_sda_oe_n, // low while acknowledging
   input wire logic i_stop_req, // stop request
   input wire logic o_stop_ack, // stop acknowledge
   input wire logic o_addressed // slave addressed
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   // ==========================================================
   // helper state: mirrored control bits, stretch length
   logic stop_holdoff_enable_q; // holdoff bit as last written
   logic independent_slave_rate_q; // independent rate bit as last written
   int unsigned low_cnt; // consecutive stretch cycles
   // mirror writes with the same one-cycle latency as the block
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         stop_holdoff_enable_q <= 1'b0;
         independent_slave_rate_q <= 1'b0;
         low_cnt <= 0;
      end else begin
         if (i_bus.wr && i_bus.addr == iam_pkg::FILTER_STOP_OFS) begin
            stop_holdoff_enable_q <= i_bus.wdata[iam_pkg::HOLDOFF_EN_BIT];
         end
         if (i_bus.wr && i_bus.addr == iam_pkg::ADDR_MODE_OFS) begin
            independent_slave_rate_q <= i_bus.wdata[iam_pkg::INDEP_RATE_BIT];
         end
         low_cnt <= o_scl_oe_n ? 0 : low_cnt + 1;
      end
   end
   // ==========================================================
   // sequences of the stop handshake and the acknowledge slot
   sequence req_rise;
      $rose(i_stop_req);
   endsequence
   sequence ack_soon;
      ##[1:300] o_stop_ack;
   endsequence
   sequence ack_begin;
      $fell(o_sda_oe_n);
   endsequence
   sequence ack_held;
      !o_sda_oe_n [*4];
   endsequence
   // ==========================================================
   // assertions
   a_rd_data_idle:
      assert property (!$past(i_bus.rd) |-> o_rd_data == 8'h00)
      else $error("read data outside its slot");
   a_reserved_zero:
      assert property ($past(i_bus.rd) && $past(i_bus.addr) == iam_pkg::ADDR_MODE_OFS
         |-> !o_rd_data[5]) else $error("reserved bit reads one");
   a_stretch_only_indep:
      assert property (!o_scl_oe_n |-> independent_slave_rate_q) else $error("stretch without rate bit");
   a_stretch_bounded:
      assert property (low_cnt <= SLAVE_BIT_CYC) else $error("stretch too long");
   a_stop_prompt_off:
      assert property (i_stop_req && !stop_holdoff_enable_q |=> o_stop_ack) else $error("stop delayed");
   a_stop_ack_bounded:
      assert property (req_rise |-> ack_soon) else $error("stop never acknowledged");
   a_ack_drop:
      assert property (!i_stop_req |=> !o_stop_ack) else $error("ack outlives request");
   a_ack_holds:
      assert property (ack_begin |-> ack_held) else $error("acknowledge slot too short");
   a_drive_low_only:
      assert property (!o_scl_out && !o_sda_out) else $error("line driven high");
endmodule

bind iam_addr_match iam_addr_match_monitor #(.SLAVE_BIT_CYC(SLAVE_BIT_CYC)) i_mon (
   .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_bus(i_bus), .o_rd_data(o_rd_data),
   .i_scl(i_scl), .i_sda(i_sda), .o_scl_out(o_scl_out), .o_scl_oe_n(o_scl_oe_n),
   .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n), .i_stop_req(i_stop_req),
   .o_stop_ack(o_stop_ack), .o_addressed(o_addressed));

/* File: iam_bus_master_model.sv */
`timescale 1ns/100ps
// ==========================================================
// open-drain bus master, 40 ns per clock phase
module iam_bus_master_model (
   input wire logic i_ref_clk, // reference clock
   input wire logic i_scl, // resolved clock line
   input wire logic i_sda, // resolved data line
   output logic o_scl_rel, // high releases clock line
   output logic o_sda_rel, // high releases data line
   output int o_stretch // cycles spent on a held clock
);
   logic ack_dummy; // unused sample of the stop bit
   // lines released, clock stands still outside frames
   initial begin
      o_scl_rel = 1'b1;
      o_sda_rel = 1'b1;
      o_stretch = 0;
   end
   // one clock phase
   task automatic half;
      repeat (4) @(posedge i_ref_clk);
   endtask
   // release clock, honour any stretch, then hold high
   task automatic rise;
      o_scl_rel <= 1'b1;
      @(posedge i_ref_clk);
      for (int n = 0; n < 200 && !i_scl; n++) begin // bounded wait
         @(posedge i_ref_clk);
         o_stretch <= o_stretch + 1;
      end
      // release edge plus three keeps the high phase at 40 ns
      repeat (3) @(posedge i_ref_clk);
   endtask
   // data changes only mid low phase
   task automatic put_bit(input logic b, output logic r);
      o_scl_rel <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      o_sda_rel <= b;
      repeat (2) @(posedge i_ref_clk);
      rise();
      r = i_sda;
   endtask
   task automatic start_cond;
      half();
      o_sda_rel <= 1'b0;
      half();
   endtask
   // msb first, ninth slot left released for the slave
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) put_bit(b[i], r);
      put_bit(1'b1, r);
      ack = !r;
   endtask
   task automatic stop_cond;
      put_bit(1'b0, ack_dummy);
      o_sda_rel <= 1'b1;
      half();
   endtask
endmodule

/* File: test_iam_addr_match.sv */
`timescale 1ns/100ps
// ==========================================================
// self-checking bench for the address matcher
module test_iam_addr_match;
   logic clk = 1'b0; // reference clock
   logic nrst = 1'b0; // reset, active low
   iam_pkg::iam_bus_type bus = '0; // register port
   logic stop_req = 1'b0; // power controller request
   logic [7:0] rd_data; // read data
   logic scl_out, scl_oe_n, sda_out, sda_oe_n, stop_ack, addressed; // dut outputs
   logic m_scl, m_sda; // model releases
   int stretch; // model stretch count
   wire logic scl = m_scl & (scl_oe_n | scl_out); // pulled up, wired and
   wire logic sda = m_sda & (sda_oe_n | sda_out); // pulled up, wired and
   int err_total = 0;
   int tests_run = 0;
   logic ack1, ack2; // acknowledge samples
   int s0; // stretch count before a frame
   always #5 clk = ~clk;
   // ==========================================================
   // design, bus model; short bit time keeps stretches brief
   iam_addr_match #(.SLAVE_BIT_CYC(8)) i_iam_addr_match (.i_ref_clk(clk), .i_nrst(nrst),
      .i_bus(bus), .o_rd_data(rd_data), .i_scl(scl), .i_sda(sda), .o_scl_out(scl_out),
      .o_scl_oe_n(scl_oe_n), .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
      .i_stop_req(stop_req), .o_stop_ack(stop_ack), .o_addressed(addressed));
   iam_bus_master_model i_iam_bus_master_model (.i_ref_clk(clk), .i_scl(scl), .i_sda(sda),
      .o_scl_rel(m_scl), .o_sda_rel(m_sda), .o_stretch(stretch));
   // ==========================================================
   // register port and compare tasks
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 chk(rd_data, exp, "register read");
   endtask
   // set the mode, send one address frame, compare the acknowledge
   task automatic match(input logic [7:0] mode, input logic [7:0] b, input logic exp);
      wr(iam_pkg::ADDR_MODE_OFS, mode);
      i_iam_bus_master_model.start_cond();
      i_iam_bus_master_model.send_byte(b, ack1);
      i_iam_bus_master_model.stop_cond();
      chk({7'h0, ack1}, {7'h0, exp}, "address acknowledge");
   endtask
   task automatic req_now(input logic exp);
      @(posedge clk);
      stop_req <= 1'b1;
      @(posedge clk);
      #1 chk({7'h0, stop_ack}, {7'h0, exp}, "stop ack");
   endtask
   // hold the request until answered, then drop it
   task automatic req_end;
      for (int n = 0; n < 400 && stop_ack !== 1'b1; n++) @(posedge clk);
      chk({7'h0, stop_ack}, 8'h01, "stop ack late");
      @(posedge clk);
      stop_req <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   // request arrives while an address byte is on the wire
   task automatic mid_req(input logic exp);
      i_iam_bus_master_model.start_cond();
      fork
         i_iam_bus_master_model.send_byte(8'h40, ack1);
         begin
            repeat (20) @(posedge clk);
            req_now(exp);
         end
      join
      if (!exp) chk({7'h0, stop_ack}, 8'h00, "ack before byte end");
      i_iam_bus_master_model.stop_cond();
      req_end();
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // watchdog, about seventeen times the expected 18 us of traffic
   initial begin
      #300000;
      err_total++;
      report_and_stop();
   end
   // ==========================================================
   // main sequence
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i <= int'(iam_pkg::SLAVE_STAT_OFS); i++) rchk(4'(i), 8'h00);
      wr(iam_pkg::ADDR_MODE_OFS, 8'hff);
      rchk(iam_pkg::ADDR_MODE_OFS, 8'hdf);
      wr(iam_pkg::FILTER_STOP_OFS, 8'hff);
      rchk(iam_pkg::FILTER_STOP_OFS, 8'h80);
      wr(iam_pkg::FILTER_STOP_OFS, 8'h00);
      $display("test registers done");
      wr(iam_pkg::PRIMARY_ADDR_OFS, 8'h40);
      wr(iam_pkg::RANGE_UPPER_OFS, 8'h50);
      wr(iam_pkg::SLAVE_CTRL_OFS, 8'h01);
      match(8'h00, 8'h40, 1'b1);
      match(8'h00, 8'h42, 1'b0);
      match(8'h00, 8'h50, 1'b0);
      match(8'h08, 8'h42, 1'b1);
      match(8'h08, 8'h50, 1'b1);
      match(8'h08, 8'h52, 1'b0);
      match(8'h08, 8'h3e, 1'b0);
      match(8'h00, 8'h00, 1'b0);
      match(8'h80, 8'h00, 1'b1);
      match(8'h40, 8'h40, 1'b0);
      match(8'h45, 8'hf2, 1'b0);
      $display("test matching done");
      wr(iam_pkg::PRIMARY_ADDR_OFS, 8'h34);
      i_iam_bus_master_model.start_cond();
      i_iam_bus_master_model.send_byte(8'hf4, ack1);
      i_iam_bus_master_model.send_byte(8'h9a, ack2);
      chk({7'h0, addressed}, 8'h01, "addressed");
      // clock parked high in the ack slot: byte still busy, slave addressed
      rchk(iam_pkg::SLAVE_STAT_OFS, 8'h03);
      i_iam_bus_master_model.stop_cond();
      chk({6'h0, ack1, ack2}, 8'h03, "ten-bit acks");
      wr(iam_pkg::PRIMARY_ADDR_OFS, 8'h40);
      $display("test ten-bit done");
      s0 = stretch;
      match(8'h10, 8'h40, 1'b1);
      chk({7'h0, stretch > s0}, 8'h01, "stretch seen");
      s0 = stretch;
      match(8'h00, 8'h40, 1'b1);
      chk({7'h0, stretch > s0}, 8'h00, "stretch unexpected");
      $display("test stretch done");
      mid_req(1'b1);
      wr(iam_pkg::FILTER_STOP_OFS, 8'h80);
      mid_req(1'b0);
      req_now(1'b1);
      req_end();
      wr(iam_pkg::SLAVE_CTRL_OFS, 8'h00);
      mid_req(1'b1);
      $display("test holdoff done");
      report_and_stop();
   end
endmodule
